// ### rtl/burst_flash_host_port.sv
// Host port of the flash device: buffer RAM, async and burst reads, array path
`timescale 1ns/1ns
`include "flash_port_defines.svh"
module burst_flash_host_port #(
  parameter int DW = `HP_DATA_W,
  parameter int AW = `HP_ADDR_W,
  parameter int FIFO_DEPTH = `HP_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic host_clk_i,
  input wire logic chip_sel_n_i,
  input wire logic out_en_n_i,
  input wire logic write_n_i,
  input wire logic address_valid_strobe_n_i,
  input wire logic [AW-1:0] address_pins_i,
  input wire logic [DW-1:0] data_pins_i,
  output logic [DW-1:0] data_pins_o,
  output logic data_pins_oe_o,
  output logic rdy_o,
  output logic rdy_oe_o,
  output logic done_pin_o,
  output logic done_pin_oe_o,
  input wire logic hw_reset_pin_n_i,
  input wire logic power_good_i,
  input wire logic done_pin_drive_enable_i,
  input wire logic sync_read_i,
  input wire logic [2:0] burst_len_i,
  input wire logic [3:0] read_latency_i,
  input wire logic boot_wp_i,
  input wire logic array_wp_i,
  input wire logic reset_cmd_valid_i,
  input wire flash_port_pkg::reset_kind_t reset_cmd_i,
  input wire logic load_start_i,
  input wire logic prog_start_i,
  input wire logic [1:0] sector_count_i,
  input wire logic [1:0] sector_sel_i,
  input wire logic arr_in_valid_i,
  input wire logic [DW+5:0] arr_in_data_i,
  output logic arr_in_ready_o,
  output logic arr_out_valid_o,
  output logic [DW+5:0] arr_out_data_o,
  input wire logic arr_out_ready_i,
  output logic busy_o,
  output logic [3:0] status_o
);
  import flash_port_pkg::*;

  localparam logic [AW-1:0] ONE = AW'(1);
  localparam int ACC_CYC = `HP_ACCESS_CYC;

  typedef struct packed {
    logic [2:0] hclk_q;
    logic [2:0] we_q;
    logic [1:0] avd_q;
    logic [1:0] cs_q;
    logic [1:0] oe_q;
    logic [1:0] hrst_q;
    logic [1:0] pg_q;
    logic [1:0][AW-1:0] a_q;
    logic [1:0][DW-1:0] d_q;
    logic [AW-1:0] addr;
    logic [3:0] lat;
    logic [9:0] beats;
    logic bursting;
    logic rdy;
    logic [DW-1:0] dout;
    logic dout_oe;
    logic rdy_oe;
    logic done_oe;
    logic done_lvl;
    op_state_t op;
    logic [9:0] ptr;
    logic [9:0] left;
    logic out_valid;
    logic [DW+5:0] out_data;
    logic ecc1;
    logic ecc2;
    logic refused;
    logic busy;
  } port_state_t;

  port_state_t s;
  port_state_t n;
  logic [1:0] rst_q;
  logic rst_n;
  logic [DW-1:0] buf_mem [`HP_BUF_WORDS];

  logic hclk_rise;
  logic we_rise;
  logic selected;
  logic host_wr;
  logic [3:0] lat_eff;
  logic [AW-1:0] bmask;
  logic [9:0] sc_words;
  logic fifo_valid;
  logic [DW+5:0] fifo_data;
  logic fifo_rdy;
  logic [DW-1:0] dec_data;
  logic dec_sgl;
  logic dec_dbl;
  logic [5:0] enc_chk;
  logic [DW-1:0] prog_word;
  logic mem_we;
  logic [10:0] mem_wa;
  logic [DW-1:0] mem_wd;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // 0 boot buffer, 1 data buffer, 2 status word, 3 unmapped
  function automatic logic [1:0] region(input logic [AW-1:0] a);
    if (a < `HP_DATA_BASE) begin
      region = 2'd0;
    end else if (a < `HP_DATA_END) begin
      region = 2'd1;
    end else if (a == `HP_STATUS_ADDR) begin
      region = 2'd2;
    end else begin
      region = 2'd3;
    end
  endfunction

  function automatic logic [3:0] status_word();
    status_word = '0;
    status_word[`HP_ST_BUSY] = s.busy; // R14
    status_word[`HP_ST_ECC1] = s.ecc1;
    status_word[`HP_ST_ECC2] = s.ecc2;
    status_word[`HP_ST_REFUSED] = s.refused;
  endfunction

  function automatic logic [DW-1:0] read_word(input logic [AW-1:0] a);
    unique case (region(a))
      2'd0, 2'd1: read_word = buf_mem[a[10:0]];
      2'd2: read_word = DW'(status_word());
      2'd3: read_word = '0;
    endcase
  endfunction

  // Linear bursts keep the upper address bits and wrap the low ones
  function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a, input logic [AW-1:0] m);
    next_addr = (a & ~m) | ((a + ONE) & m); // R5 R24
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and submodules

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  stream_fifo #(.W(DW + 6), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .in_valid_i(arr_in_valid_i),
    .in_data_i(arr_in_data_i),
    .in_ready_o(arr_in_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(fifo_rdy)
  );

  secded16 u_dec (
    .data_i(fifo_data[DW-1:0]),
    .check_i(fifo_data[DW+5:DW]),
    .enc_check_o(),
    .data_o(dec_data),
    .single_o(dec_sgl),
    .double_o(dec_dbl)
  );

  secded16 u_enc (
    .data_i(prog_word),
    .check_i(6'h00),
    .enc_check_o(enc_chk),
    .data_o(),
    .single_o(),
    .double_o()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n = s;
    n.hclk_q = {s.hclk_q[1:0], host_clk_i};
    n.we_q = {s.we_q[1:0], write_n_i};
    n.avd_q = {s.avd_q[0], address_valid_strobe_n_i};
    n.cs_q = {s.cs_q[0], chip_sel_n_i};
    n.oe_q = {s.oe_q[0], out_en_n_i};
    n.hrst_q = {s.hrst_q[0], hw_reset_pin_n_i};
    n.pg_q = {s.pg_q[0], power_good_i};
    n.a_q = {s.a_q[0], address_pins_i};
    n.d_q = {s.d_q[0], data_pins_i};
    hclk_rise = s.hclk_q[1] & ~s.hclk_q[2]; // R4
    we_rise = s.we_q[1] & ~s.we_q[2];
    selected = ~s.cs_q[1];
    lat_eff = (read_latency_i < 4'(`HP_MIN_LATENCY)) ? 4'(`HP_MIN_LATENCY) : read_latency_i; // R7
    unique case (burst_len_i)
      3'd1: bmask = AW'(3);
      3'd2: bmask = AW'(7);
      3'd3: bmask = AW'(15);
      3'd4: bmask = AW'(31);
      default: bmask = '0;
    endcase
    if (sector_count_i == 2'd0) begin
      sc_words = 10'(`HP_SECTOR_WORDS);
    end else if (sector_count_i > 2'(`HP_MAX_SECTORS)) begin
      sc_words = 10'(`HP_MAX_SECTORS * `HP_SECTOR_WORDS); // R8
    end else begin
      sc_words = 10'(sector_count_i * `HP_SECTOR_WORDS);
    end

    // Host writes, data taken on the strobe's rising edge
    host_wr = we_rise && selected; // R23
    mem_we = 1'b0;
    mem_wa = s.a_q[1][10:0];
    mem_wd = s.d_q[1];
    if (host_wr && s.pg_q[1]) begin // R16
      mem_we = (region(s.a_q[1]) == 2'd1) || (region(s.a_q[1]) == 2'd0 && !boot_wp_i); // R16 R18
    end

    // Address capture and bursts
    if (!selected) begin
      n.bursting = 1'b0; // R21
      n.rdy = 1'b0;
    end else if (!sync_read_i) begin
      n.bursting = 1'b0;
      n.rdy = 1'b0;
      if (!s.avd_q[1]) begin
        n.addr = s.a_q[1]; // R13
      end
    end else if (hclk_rise) begin
      if (!s.avd_q[1]) begin
        n.addr = s.a_q[1]; // R12 R20
        n.lat = 4'd0;
        n.beats = 10'd0;
        n.bursting = 1'b1;
        n.rdy = 1'b0;
      end else if (s.bursting) begin
        if (s.lat != lat_eff) begin
          n.lat = s.lat + 4'd1; // R7
        end
        if (n.lat == lat_eff) begin
          if (bmask == '0 && s.beats == 10'(`HP_CONT_WORDS)) begin
            n.bursting = 1'b0; // R6
            n.rdy = 1'b0;
          end else begin
            if (s.rdy) begin
              n.addr = (bmask == '0) ? s.addr + ONE : next_addr(s.addr, bmask); // R5 R24
            end
            n.beats = s.beats + 10'd1;
            n.rdy = 1'b1; // R11
          end
        end
      end
    end
    n.dout = read_word(n.addr); // R1 R2
    n.dout_oe = selected && !s.oe_q[1] && s.we_q[1]; // R3 R22
    n.rdy_oe = selected && sync_read_i; // R11

    // Array transfers
    fifo_rdy = (s.op == OP_LOAD) && !host_wr;
    prog_word = buf_mem[11'(`HP_BOOT_WORDS) + {1'b0, s.ptr}];
    unique case (s.op)
      OP_IDLE: begin
        if (load_start_i) begin
          n.op = OP_LOAD;
          n.ptr = {sector_sel_i, 8'h00};
          n.left = sc_words; // R8
          n.ecc1 = 1'b0;
          n.ecc2 = 1'b0;
          n.refused = 1'b0;
        end else if (prog_start_i) begin
          n.ecc1 = 1'b0;
          n.ecc2 = 1'b0;
          n.refused = array_wp_i; // R16
          if (!array_wp_i) begin
            n.op = OP_PROG;
            n.ptr = {sector_sel_i, 8'h00};
            n.left = sc_words;
          end
        end
      end
      OP_LOAD: begin
        if (fifo_valid && fifo_rdy) begin
          mem_we = 1'b1;
          mem_wa = 11'(`HP_BOOT_WORDS) + {1'b0, s.ptr};
          mem_wd = dec_data; // R17
          n.ecc1 = s.ecc1 | (dec_sgl & ~dec_dbl); // R17
          n.ecc2 = s.ecc2 | dec_dbl; // R17
          n.ptr = s.ptr + 10'd1;
          n.left = s.left - 10'd1;
          if (s.left == 10'd1) begin
            n.op = OP_IDLE;
          end
        end
      end
      OP_PROG: begin
        if (!s.out_valid || arr_out_ready_i) begin
          n.out_valid = s.left != 10'd0;
          if (s.left != 10'd0) begin
            n.out_data = {enc_chk, prog_word}; // R17
            n.ptr = s.ptr + 10'd1;
            n.left = s.left - 10'd1;
          end else begin
            n.op = OP_IDLE;
          end
        end
      end
      default: n.op = OP_IDLE;
    endcase

    // Resets; buffer RAM contents survive all of them
    if (!s.pg_q[1] || !s.hrst_q[1] || (reset_cmd_valid_i && reset_cmd_i != RST_CORE)) begin
      n.op = OP_IDLE; // R15
      n.out_valid = 1'b0;
      n.bursting = 1'b0;
      n.rdy = 1'b0;
      n.ecc1 = 1'b0;
      n.ecc2 = 1'b0;
      n.refused = 1'b0;
    end else if (reset_cmd_valid_i) begin
      n.op = OP_IDLE; // R15
      n.out_valid = 1'b0;
    end
    n.busy = n.op != OP_IDLE; // R14
    // Open drain: pulls low while busy when enabled or selected with outputs on, released on completion
    n.done_oe = n.busy && (done_pin_drive_enable_i || (selected && !s.oe_q[1])); // R9 R10 R14
    n.done_lvl = 1'b0;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.hclk_q <= '0;
      s.we_q <= '1;
      s.avd_q <= '1;
      s.cs_q <= '1;
      s.oe_q <= '1;
      s.hrst_q <= '1;
    end else begin
      s <= n;
    end
  end

  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      buf_mem[mem_wa] <= mem_wd;
    end
  end

  assign data_pins_o = s.dout;
  assign data_pins_oe_o = s.dout_oe;
  assign rdy_o = s.rdy;
  assign rdy_oe_o = s.rdy_oe;
  assign done_pin_o = s.done_lvl;
  assign done_pin_oe_o = s.done_oe;
  assign arr_out_valid_o = s.out_valid;
  assign arr_out_data_o = s.out_data;
  assign busy_o = s.busy;
  assign status_o = status_word();

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n);

  a_float_deselect: assert property (s.cs_q[1] |=> !data_pins_oe_o) // R3
    else $error("data pins driven while deselected");
  a_oe_gates_data: assert property (s.oe_q[1] |=> !data_pins_oe_o) // R22
    else $error("data pins driven with outputs disabled");
  a_rdy_only_sel: assert property (s.cs_q[1] |=> !rdy_oe_o && !rdy_o) // R11
    else $error("ready driven while deselected");
  a_done_hiz: assert property
    (!done_pin_drive_enable_i && s.cs_q[1] |=> !done_pin_oe_o) // R10
    else $error("completion pin driven before enable");
  a_done_held: assert property
    (done_pin_drive_enable_i && n.busy |=> done_pin_oe_o && !done_pin_o) // R9
    else $error("completion pin not pulled low while busy");
  a_addr_capture: assert property
    (sync_read_i && selected && hclk_rise && !s.avd_q[1] |=> s.addr == $past(s.a_q[1])) // R12
    else $error("burst start address not captured");
  a_latency_min: assert property ($rose(rdy_o) |-> s.lat >= 4'd4) // R7
    else $error("burst data before four host clocks");
  a_wrap_group: assert property
    (s.rdy && s.bursting && hclk_rise && s.avd_q[1] && selected && bmask != '0 &&
     n.lat == lat_eff && (s.addr & bmask) == bmask |=> (s.addr & $past(bmask)) == '0) // R24
    else $error("linear burst failed to wrap");
  a_cont_limit: assert property (rdy_o |-> s.beats <= 10'd512) // R6
    else $error("continuous burst beyond 512 words");
  a_boot_protect: assert property
    (mem_we && s.op != OP_LOAD |-> s.pg_q[1] && !(mem_wa < 11'd512 && boot_wp_i)) // R16
    else $error("protected or unpowered write accepted");
  a_sector_limit: assert property // R8 R19
    (s.op != OP_IDLE |-> s.left <= 10'(`HP_PAGE_MAIN_BYTES / 2))
    else $error("transfer longer than two sectors");
  a_double_flag: assert property (s.op == OP_LOAD && fifo_valid && fifo_rdy && dec_dbl // R17
    |=> status_o[2])
    else $error("double error not flagged");
  a_async_read: assert property
    (!sync_read_i && selected && $fell(s.oe_q[1]) && s.we_q[1] |-> ##[1:ACC_CYC] data_pins_oe_o) // R13
    else $error("async read data late");

  c_burst: cover property (sync_read_i && s.bursting && s.rdy && s.beats == 10'd4);
  c_load_done: cover property (s.op == OP_LOAD ##1 s.op == OP_IDLE);
  c_prog_word: cover property (arr_out_valid_o && arr_out_ready_i);
  c_wp_refuse: cover property (status_o[3]);
endmodule

// ### rtl/flash_port_defines.svh
// Constants of the burst flash host port
// Function
// [R1] Host data path is sixteen bits wide, both directions.
// [R2] Sixteen address inputs select buffer RAM words and the register space.
// [R3] Data pins float while deselected or while outputs are disabled.
// [R4] Burst reads run from a host clock up to the stated maximum.
// [R5] Linear bursts of 4, 8, 16 or 32 words wrap within the burst.
// [R6] Continuous burst delivers up to 512 consecutive words.
// [R7] Burst data waits the programmed latency, never fewer than four host clocks.
// [R8] Multiple-sector load takes its count from a setting limited to two.
// [R9] Completion is signalled on an open-drain pin with a pull resistor.
// [R10] Completion pin floats after power-up; once enabled it stays driven. The port drives it only while busy, even before enable when selected with OE low.
// [R11] Ready flags valid burst data and is driven only while selected.
// [R12] Burst start address is taken on the first host clock rise with strobe low.
// [R13] Asynchronous random reads (about 76 ns) and random writes are accepted.
// [R14] Ready/busy shows on the completion pin and in a pollable status word.
// [R15] Cold, warm, hot and core resets, reset pin and power detector exist.
// [R16] Boot buffer and array have write protection; power loss blocks writes.
// [R17] Array data gets two-bit error detection and one-bit correction.
// [R18] Buffer RAM splits into 1 KB boot buffer and 2 KB data buffer.
// [R19] An array page holds 1K main bytes plus 32 spare bytes.
// [R20] Host holds the address strobe low one clock; address taken on that rise.
// [R21] Deselect puts the port in standby and floats its pins.
// [R22] Output buffers drive during a read only while output enable is low.
// [R23] Writes take their data on the rising edge of the write strobe.
// [R24] A linear burst wraps to the start of its aligned group.
`ifndef FLASH_PORT_DEFINES_SVH
`define FLASH_PORT_DEFINES_SVH
`define HP_DATA_W 16
`define HP_ADDR_W 16
`define HP_CHK_W 6
`define HP_FIFO_DEPTH 16
`define HP_BOOT_WORDS 512
`define HP_DATA_WORDS 1024
`define HP_BUF_WORDS 1536
`define HP_DATA_BASE 16'h0200
`define HP_DATA_END 16'h0600
`define HP_STATUS_ADDR 16'hf000
`define HP_SECTOR_WORDS 256
`define HP_MAX_SECTORS 2
`define HP_MIN_LATENCY 4
`define HP_CONT_WORDS 512
`define HP_PAGE_MAIN_BYTES 1024
`define HP_PAGE_SPARE_BYTES 32
`define HP_HCLK_MAX_MHZ 54
`define HP_CLK_NS 8
`define HP_ACCESS_NS 76
`define HP_ACCESS_CYC (`HP_ACCESS_NS / `HP_CLK_NS)
`define HP_ST_BUSY 0
`define HP_ST_ECC1 1
`define HP_ST_ECC2 2
`define HP_ST_REFUSED 3
`endif

// ### rtl/flash_port_pkg.sv
// Types shared by the burst flash host port
package flash_port_pkg;
  typedef enum logic [1:0] {OP_IDLE, OP_LOAD, OP_PROG} op_state_t;
  typedef enum logic [1:0] {RST_COLD, RST_WARM, RST_HOT, RST_CORE} reset_kind_t;
endpackage

// ### rtl/secded16.sv
// Single-correct double-detect code over one 16-bit word
`timescale 1ns/1ns
module secded16 (
  input wire logic [15:0] data_i,
  input wire logic [5:0] check_i,
  output logic [5:0] enc_check_o,
  output logic [15:0] data_o,
  output logic single_o,
  output logic double_o
);
  function automatic logic [21:1] spread(input logic [15:0] d);
    int j;
    j = 0;
    spread = '0;
    for (int p = 1; p <= 21; p++) begin
      if ((p & (p - 1)) != 0) begin
        spread[p] = d[j];
        j++;
      end
    end
  endfunction

  function automatic logic [15:0] gather(input logic [21:1] c);
    int j;
    j = 0;
    gather = '0;
    for (int p = 1; p <= 21; p++) begin
      if ((p & (p - 1)) != 0) begin
        gather[j] = c[p];
        j++;
      end
    end
  endfunction

  function automatic logic [4:0] syndrome(input logic [21:1] c);
    syndrome = '0;
    for (int p = 1; p <= 21; p++) begin
      if (c[p]) begin
        syndrome = syndrome ^ 5'(p);
      end
    end
  endfunction

  logic [21:1] cw;
  logic [4:0] syn;
  logic [4:0] enc_syn;
  logic par_bad;

  always_comb begin
    enc_syn = syndrome(spread(data_i));
    enc_check_o = {^{spread(data_i), enc_syn}, enc_syn};
    cw = spread(data_i);
    for (int k = 0; k < 5; k++) begin
      cw[1 << k] = check_i[k];
    end
    syn = syndrome(cw);
    par_bad = ^{cw, check_i[5]};
    single_o = par_bad;
    double_o = (syn != 5'h00) && !par_bad;
    if (par_bad && syn != 5'h00 && syn <= 5'd21) begin
      cw[syn] = ~cw[syn];
    end
    data_o = gather(cw);
  end
endmodule

// ### rtl/stream_fifo.sv
// Valid/ready FIFO on one clock
`timescale 1ns/1ns
module stream_fifo #(
  parameter int W = 22,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
    logic in_rdy;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t n;
  logic [W-1:0] mem [DEPTH];
  logic push;
  logic pop;

  always_comb begin
    n = s;
    push = in_valid_i && s.in_rdy;
    pop = (s.cnt != '0) && out_ready_i;
    if (push) begin
      n.wp = s.wp + 1'b1;
    end
    if (pop) begin
      n.rp = s.rp + 1'b1;
    end
    n.cnt = s.cnt + (PW+1)'(push) - (PW+1)'(pop);
    n.in_rdy = n.cnt != (PW+1)'(DEPTH);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[s.wp] <= in_data_i;
    end
  end

  assign in_ready_o = s.in_rdy;
  assign out_valid_o = s.cnt != '0;
  assign out_data_o = mem[s.rp];
endmodule

// ### verification/host_bus_model.sv
// Host processor model: asynchronous pin cycles and host-clocked bursts
`timescale 1ns/1ns
module host_bus_model (
  input wire logic clk_i,
  input wire logic [15:0] dut_data_i,
  input wire logic dut_oe_i,
  input wire logic rdy_i,
  output logic host_clk_o,
  output logic chip_sel_n_o,
  output logic out_en_n_o,
  output logic write_n_o,
  output logic address_valid_strobe_n_o,
  output logic [15:0] address_pins_o,
  output wire logic [15:0] data_pins_o
);
  logic [15:0] host_dq = 16'h0, last_q = 16'h0;
  logic host_drv = 1'b0;
  // Undriven data pins show a pattern that flips every cycle
  assign data_pins_o = host_drv ? host_dq : dut_oe_i ? dut_data_i : ~last_q;
  always @(posedge clk_i) last_q <= data_pins_o;
  initial begin
    {host_clk_o, chip_sel_n_o, out_en_n_o, write_n_o} = 4'b0111;
    address_valid_strobe_n_o = 1'b1;
    address_pins_o = 16'h0;
  end
  ////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic write_word(input logic [15:0] a, input logic [15:0] d);
    step(1);
    chip_sel_n_o = 1'b0;
    address_pins_o = a;
    host_dq = d;
    host_drv = 1'b1;
    write_n_o = 1'b0;
    step(4);
    write_n_o = 1'b1;
    step(4);
    chip_sel_n_o = 1'b1;
    host_drv = 1'b0;
  endtask
  task automatic read_word(input logic [15:0] a, output logic [15:0] d, output logic oe);
    step(1);
    {chip_sel_n_o, out_en_n_o, address_valid_strobe_n_o} = 3'b000;
    address_pins_o = a;
    step(6);
    d = dut_data_i;
    oe = dut_oe_i;
    {chip_sel_n_o, out_en_n_o, address_valid_strobe_n_o} = 3'b111;
  endtask
  // Samples each host period just before the next rise; clock stands low between frames
  task automatic burst(input logic [15:0] a, input int n, output int lat,
                       output logic [15:0] w [4]);
    int got;
    got = 0;
    lat = -1;
    step(1);
    {chip_sel_n_o, out_en_n_o, address_valid_strobe_n_o} = 3'b000;
    address_pins_o = a;
    step(10);
    for (int k = 0; k < 64 && got < n; k++) begin
      host_clk_o = 1'b1;
      step(10);
      address_valid_strobe_n_o = 1'b1;
      address_pins_o = ~a;
      host_clk_o = 1'b0;
      step(9);
      if (rdy_i === 1'b1) begin
        if (got == 0) lat = k;
        w[got] = dut_data_i;
        got++;
      end
      step(1);
    end
    {chip_sel_n_o, out_en_n_o} = 2'b11;
  endtask
endmodule

// ### verification/test_burst_flash_host_port.sv
// Self-checking bench of the burst flash host port
`timescale 1ns/1ns
module test_burst_flash_host_port;
  import flash_port_pkg::*;
  logic clk_i = 1'b0, resetn_i = 1'b0, hw_rst_n = 1'b1, power_good = 1'b1, done_en = 1'b0;
  logic sync_read = 1'b0, boot_wp = 1'b0, array_wp = 1'b0, rcmd_valid = 1'b0;
  logic load_start = 1'b0, prog_start = 1'b0, arr_in_valid = 1'b0, arr_out_ready = 1'b0;
  logic out_open = 1'b0;
  logic [2:0] burst_len = 3'h1, cyc = 3'h0;
  logic [3:0] read_lat = 4'h4, status_o;
  logic [1:0] sector_count = 2'h0, sector_sel = 2'h0;
  reset_kind_t rcmd = RST_COLD;
  logic host_clk, cs_n, oe_n, we_n, avs_n, dq_oe, rdy_o, rdy_oe, done_oe, in_ready;
  logic out_valid, busy_o, done_lvl;
  logic [15:0] addr, dq, dq_o, a0, ea;
  logic [21:0] out_data, arr_in_data = 22'h0;
  logic [21:0] got [2];
  logic [15:0] w [4];
  logic [2:0] blt [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
  logic [3:0] latt [5] = '{4'h2, 4'h4, 4'h6, 4'h5, 4'h4};
  int errors = 0, n_tests = 0, fed = 0, feed_lim = 0, taken = 0, lat, len;
  always #4 clk_i = ~clk_i;
  ////////////////////////////////////////
  burst_flash_host_port DUT (.clk_i(clk_i), .resetn_i(resetn_i), .host_clk_i(host_clk),
    .chip_sel_n_i(cs_n), .out_en_n_i(oe_n), .write_n_i(we_n),
    .address_valid_strobe_n_i(avs_n), .address_pins_i(addr), .data_pins_i(dq),
    .data_pins_o(dq_o), .data_pins_oe_o(dq_oe), .rdy_o(rdy_o), .rdy_oe_o(rdy_oe),
    .done_pin_o(done_lvl), .done_pin_oe_o(done_oe), .hw_reset_pin_n_i(hw_rst_n),
    .power_good_i(power_good), .done_pin_drive_enable_i(done_en), .sync_read_i(sync_read),
    .burst_len_i(burst_len), .read_latency_i(read_lat), .boot_wp_i(boot_wp),
    .array_wp_i(array_wp), .reset_cmd_valid_i(rcmd_valid), .reset_cmd_i(rcmd),
    .load_start_i(load_start), .prog_start_i(prog_start), .sector_count_i(sector_count),
    .sector_sel_i(sector_sel), .arr_in_valid_i(arr_in_valid), .arr_in_data_i(arr_in_data),
    .arr_in_ready_o(in_ready), .arr_out_valid_o(out_valid), .arr_out_data_o(out_data),
    .arr_out_ready_i(arr_out_ready), .busy_o(busy_o), .status_o(status_o));
  host_bus_model u_host (.clk_i(clk_i), .dut_data_i(dq_o), .dut_oe_i(dq_oe), .rdy_i(rdy_o),
    .host_clk_o(host_clk), .chip_sel_n_o(cs_n), .out_en_n_o(oe_n), .write_n_o(we_n),
    .address_valid_strobe_n_o(avs_n), .address_pins_o(addr), .data_pins_o(dq));
  // Array side: zero code words in, word 40 with one bad bit and word 41 with two,
  // program words out with a periodic stall
  always @(posedge clk_i) begin
    cyc <= cyc + 3'h1;
    if (arr_in_valid && in_ready) fed <= fed + 1;
    if (out_valid && arr_out_ready) begin
      if (taken < 2) got[taken] <= out_data;
      taken <= taken + 1;
    end
  end
  always @(negedge clk_i) begin
    arr_in_valid <= fed < feed_lim;
    arr_in_data <= {20'h0, fed == 41, fed == 40 || fed == 41};
    arr_out_ready <= out_open && cyc != 3'h3;
  end
  ////////////////////////////////////////
  function automatic logic [15:0] pat(input logic [15:0] a);
    return a ^ 16'h5a5a;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic oe;
    u_host.read_word(a, d, oe);
    check(16'(oe), 16'h1, "read drive");
    check(d, exp, "read data");
  endtask
  task automatic start_op(input logic prog);
    @(negedge clk_i);
    load_start = !prog;
    prog_start = prog;
    @(negedge clk_i);
    {load_start, prog_start} = 2'b00;
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 3000 && busy_o !== 1'b0; i++) u_host.step(1);
  endtask
  task automatic tally_and_finish;
    $display("errors %0d, checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    tally_and_finish();
  end
  ////////////////////////////////////////
  initial begin
    repeat (12) @(negedge clk_i);
    resetn_i = 1'b1;
    u_host.step(6);
    check({12'h0, dq_oe, rdy_oe, done_oe, busy_o}, 16'h0, "after reset");
    for (int i = 0; i < 34; i++) u_host.write_word(16'h0200 + 16'(i), pat(16'h0200 + 16'(i)));
    rd_chk(16'h0203, pat(16'h0203));
    u_host.step(4);
    check(16'(dq_oe), 16'h0, "float when deselected");
    rd_chk(16'h0700, 16'h0);
    u_host.write_word(16'h0010, 16'h1234);
    boot_wp = 1'b1;
    u_host.write_word(16'h0010, 16'hbeef);
    boot_wp = 1'b0;
    rd_chk(16'h0010, 16'h1234);
    power_good = 1'b0;
    u_host.write_word(16'h0201, 16'h0);
    power_good = 1'b1;
    u_host.step(6);
    rd_chk(16'h0201, pat(16'h0201));
    sync_read = 1'b1;
    for (int t = 0; t < 5; t++) begin
      burst_len = blt[t];
      read_lat = latt[t];
      len = blt[t] == 3'h0 ? 0 : 4 << (blt[t] - 3'h1);
      a0 = 16'h0200 + 16'(len == 0 ? 30 : len - 2);
      u_host.burst(a0, 4, lat, w);
      check(16'(lat), 16'(latt[t] < 4'h4 ? 4'h4 : latt[t]), "burst latency");
      for (int i = 0; i < 4; i++) begin
        ea = len == 0 ? a0 + 16'(i) : 16'h0200 + 16'((len - 2 + i) % len);
        check(w[i], pat(ea), "burst word");
      end
      u_host.step(4);
      check(16'(rdy_oe), 16'h0, "ready released");
    end
    sync_read = 1'b0;
    for (int k = 0; k < 5; k++) begin
      done_en = k[0];
      start_op(1'b0);
      u_host.step(3);
      check({12'h0, done_lvl, busy_o, status_o[0], done_oe}, {15'h3, done_en}, "busy");
      rcmd = reset_kind_t'(k[1:0]);
      if (k < 4) rcmd_valid = 1'b1;
      else hw_rst_n = 1'b0;
      u_host.step(1);
      rcmd_valid = 1'b0;
      u_host.step(1);
      hw_rst_n = 1'b1;
      u_host.step(6);
      check(16'(busy_o), 16'h0, "reset aborts");
    end
    feed_lim = 20;
    u_host.step(40);
    check({15'h0, in_ready}, 16'h0, "fifo full refuses");
    check(16'(fed), 16'd16, "fifo depth");
    u_host.write_word(16'h0300, 16'h7777);
    {sector_count, sector_sel} = 4'hd;
    feed_lim = 512;
    start_op(1'b0);
    for (int i = 0; i < 2000 && fed < 300; i++) u_host.step(1);
    check(16'(busy_o), 16'h1, "two sector load");
    wait_idle();
    check({13'h0, busy_o, status_o[2:1]}, 16'h3, "load end");
    rd_chk(16'h0300, 16'h0);
    rd_chk(16'h0328, 16'h0);
    u_host.write_word(16'h0200, 16'h1357);
    u_host.write_word(16'h0201, 16'h2468);
    array_wp = 1'b1;
    {sector_count, sector_sel} = 4'h0;
    start_op(1'b1);
    u_host.step(4);
    check({14'h0, status_o[3], busy_o}, 16'h2, "program refused");
    array_wp = 1'b0;
    start_op(1'b1);
    u_host.step(20);
    check({14'h0, busy_o, status_o[3]}, 16'h2, "stalled program");
    out_open = 1'b1;
    wait_idle();
    check(16'(busy_o), 16'h0, "program end");
    check(16'(taken), 16'd256, "program words");
    check(got[0][15:0], 16'h1357, "program data");
    check(16'(got[0][21:16]), 16'h0033, "program check bits");
    check(got[1][15:0], 16'h2468, "program data");
    tally_and_finish();
  end
endmodule
